// [rtl/dcr_pkg.sv]
package dcr_pkg;

   localparam int INSTR_W    = 14;
   localparam int REG_ADDR_W = 7;
   localparam int DATA_W     = 8;
   localparam int PC_W       = 13;

   // field positions within the instruction word
   localparam int OPC_HI   = 13;
   localparam int OPC_LO   = 8;
   localparam int DEST_BIT = 7;
   localparam int ADDR_HI  = 6;
   localparam int ADDR_LO  = 0;
   localparam int OPC_W    = OPC_HI - OPC_LO + 1;

   localparam logic [OPC_W-1:0] DEC_OPCODE = 6'h03;
   // default for the countdown-and-skip opcode, overridable at the top
   localparam logic [OPC_W-1:0] SKIP_OPCODE_DEF = 6'h0b;

   localparam logic [PC_W-1:0]       PC_RESET   = 13'h0000;
   localparam logic [PC_W-1:0]       PC_STEP    = 13'h0001;
   localparam logic [DATA_W-1:0]     DATA_RESET = 8'h00;
   localparam logic [DATA_W-1:0]     DEC_STEP   = 8'h01;
   localparam logic [DATA_W-1:0]     DATA_ZERO  = 8'h00;
   localparam logic [INSTR_W-1:0]    INSTR_RESET = 14'h0000;
   localparam logic [REG_ADDR_W-1:0] ADDR_RESET = 7'h00;

   // four phases of one instruction cycle
   typedef enum logic [1:0] {
      PH_ONE   = 2'b00,
      PH_TWO   = 2'b01,
      PH_THREE = 2'b10,
      PH_FOUR  = 2'b11
   } dcr_phase_t;

   function automatic logic [OPC_W-1:0] dcr_opcode(
      input logic [INSTR_W-1:0] instr
   );
      return instr[OPC_HI:OPC_LO];
   endfunction

   function automatic logic dcr_is_zero(input logic [DATA_W-1:0] value);
      return value == DATA_ZERO;
   endfunction

endpackage

// [rtl/dcr_phase_if.sv]
interface dcr_phase_if;
   import dcr_pkg::*;

   dcr_phase_t phase;

   modport gen  (output phase);
   modport core (input  phase);
endinterface

// [rtl/dcr_phase.sv]
module dcr_phase (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   dcr_phase_if.gen  ph
);
   import dcr_pkg::*;

   dcr_phase_t phase_reg;
   dcr_phase_t phase_next;

   always_comb begin
      unique case (phase_reg)
         PH_ONE:   phase_next = PH_TWO;
         PH_TWO:   phase_next = PH_THREE;
         PH_THREE: phase_next = PH_FOUR;
         PH_FOUR:  phase_next = PH_ONE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         phase_reg <= PH_ONE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   assign ph.phase = phase_reg;

   phase_wrap_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (phase_reg == PH_ONE) |=> (phase_reg == PH_TWO) ##1
      (phase_reg == PH_THREE) ##1 (phase_reg == PH_FOUR) ##1
      (phase_reg == PH_ONE))
      else $error("phase sequence broken");

endmodule

// [rtl/dcr_core.sv]
// How it works
// - register operand is 0..127, destination select is one bit
// - decrement computes addressed register minus one, sent to destination
// - decrement updates zero flag only; other flags untouched
// - top six bits 00 0011 decode decrement; bit 7 dest; low 7 address
// - destination zero writes accumulator, source register unchanged
// - destination one writes result back into the addressed register
// - one program word, one instruction cycle
// - phases: decode, read register, process, write destination
// - countdown-skip reaching zero skips the following instruction
// - skip turns the next cycle into a no-operation cycle
module dcr_core #(
   parameter logic [dcr_pkg::OPC_W-1:0] SKIP_OPCODE = dcr_pkg::SKIP_OPCODE_DEF
) (
   input  wire logic                            i_clk,
   input  wire logic                            i_nrst,
   input  wire logic [dcr_pkg::INSTR_W-1:0]     i_instr,
   input  wire logic [dcr_pkg::DATA_W-1:0]      i_reg_rdata,
   output logic      [dcr_pkg::PC_W-1:0]        o_pc,
   output logic      [dcr_pkg::REG_ADDR_W-1:0]  o_reg_addr,
   output logic      [dcr_pkg::DATA_W-1:0]      o_reg_wdata,
   output logic                                 o_reg_we,
   output logic      [dcr_pkg::DATA_W-1:0]      o_acc,
   output logic                                 o_zero,
   output logic                                 o_nop_cycle,
   output logic                                 o_cycle_start
);
   import dcr_pkg::*;

   dcr_phase_if ph ();

   dcr_phase u_phase (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .ph     (ph.gen)
   );

   logic [INSTR_W-1:0]    instr_reg;
   logic [DATA_W-1:0]     data_reg;
   logic [DATA_W-1:0]     result_reg;
   logic [DATA_W-1:0]     acc_reg;
   logic                  zero_reg;
   logic [PC_W-1:0]       pc_reg;
   logic                  nop_reg;
   logic [REG_ADDR_W-1:0] addr_reg;

   logic is_dec;
   logic is_skip;
   logic dest_reg_sel;
   logic in_four;
   logic skip_taken;

   // a flushed cycle carries the skipped word but must not act on it
   assign is_dec  = !nop_reg
                    && (dcr_opcode(instr_reg) == DEC_OPCODE);
   assign is_skip = !nop_reg && (dcr_opcode(instr_reg) == SKIP_OPCODE);
   assign dest_reg_sel = instr_reg[DEST_BIT];
   assign in_four      = (ph.phase == PH_FOUR);
   assign skip_taken   = is_skip && dcr_is_zero(result_reg);

   // decode: the word at the current address is taken in phase one
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         instr_reg <= INSTR_RESET;
         addr_reg  <= ADDR_RESET;
      end else if (ph.phase == PH_ONE) begin
         instr_reg <= i_instr;
         addr_reg  <= i_instr[ADDR_HI:ADDR_LO];
      end
   end

   // read: register file answers combinationally to the held address
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         data_reg <= DATA_RESET;
      end else if (ph.phase == PH_TWO) begin
         data_reg <= i_reg_rdata;
      end
   end

   // process: wraps 0x00 to 0xff, as plain modulo arithmetic
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         result_reg <= DATA_RESET;
      end else if (ph.phase == PH_THREE) begin
         result_reg <= data_reg - DEC_STEP;
      end
   end

   // write: accumulator destination
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         acc_reg <= DATA_RESET;
      end else if (in_four && (is_dec || is_skip) && !dest_reg_sel) begin
         acc_reg <= result_reg;
      end
   end

   // zero flag follows the plain decrement only
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         zero_reg <= 1'b0;
      end else if (in_four && is_dec) begin
         zero_reg <= dcr_is_zero(result_reg);
      end
   end

   // one word per instruction: the address steps once per cycle
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pc_reg <= PC_RESET;
      end else if (in_four) begin
         pc_reg <= pc_reg + PC_STEP;
      end
   end

   // skip costs a whole extra cycle rather than a fetch jump
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         nop_reg <= 1'b0;
      end else if (in_four) begin
         nop_reg <= skip_taken;
      end
   end

   // register file write is a one-phase strobe
   assign o_reg_we = in_four && (is_dec || is_skip) && dest_reg_sel;
   assign o_reg_wdata   = result_reg;
   assign o_reg_addr    = addr_reg;
   assign o_acc         = acc_reg;
   assign o_zero        = zero_reg;
   assign o_pc          = pc_reg;
   assign o_nop_cycle   = nop_reg;
   assign o_cycle_start = (ph.phase == PH_ONE);

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   read_address_a: assert property (
      (ph.phase == PH_ONE) |=> (o_reg_addr == $past(i_instr[ADDR_HI:ADDR_LO])))
      else $error("register address not taken from word");

   write_value_a: assert property (
      (ph.phase == PH_TWO) |=> ##1 (!o_reg_we ||
      (o_reg_wdata == $past(i_reg_rdata, 2) - DEC_STEP)))
      else $error("written value is not register minus one");

   zero_update_a: assert property (
      (in_four && is_dec) |=> (o_zero == dcr_is_zero($past(result_reg))))
      else $error("zero flag not set from result");

   zero_hold_a: assert property (
      !(in_four && is_dec) |=> $stable(o_zero))
      else $error("zero flag changed outside decrement");

   decode_dec_a: assert property (
      (in_four && !nop_reg && (instr_reg[OPC_HI:OPC_LO] == DEC_OPCODE)
      && instr_reg[DEST_BIT]) |-> o_reg_we)
      else $error("decrement word not decoded");

   acc_dest_a: assert property (
      (in_four && is_dec && !dest_reg_sel) |->
      (!o_reg_we ##1 (o_acc == $past(result_reg))))
      else $error("accumulator destination wrong");

   reg_dest_a: assert property (
      (in_four && is_dec && dest_reg_sel) |=> $stable(o_acc))
      else $error("register destination touched accumulator");

   one_word_a: assert property (
      in_four |=> (o_pc == $past(o_pc) + PC_STEP) ##1 $stable(o_pc)[*3])
      else $error("address step per cycle wrong");

   skip_taken_a: assert property (
      (in_four && is_skip && dcr_is_zero(result_reg)) |=> o_nop_cycle[*4])
      else $error("zero count did not skip");

   no_skip_a: assert property (
      (in_four && !(is_skip && dcr_is_zero(result_reg))) |=> !o_nop_cycle)
      else $error("nonzero count skipped");

   // the skip itself may load the accumulator on the edge entering the flush
   nop_quiet_a: assert property (
      o_nop_cycle |-> !o_reg_we ##1 ($stable(o_acc) && $stable(o_zero)))
      else $error("flushed cycle had an effect");

   cycle_start_a: assert property (
      o_cycle_start |=> (!o_cycle_start)[*3] ##1 o_cycle_start)
      else $error("instruction cycle is not four phases");

   addr_hold_a: assert property (
      (ph.phase != PH_ONE) |=> $stable(o_reg_addr))
      else $error("register address moved inside a cycle");

   other_op_quiet_a: assert property (
      (in_four && (dcr_opcode(instr_reg) != DEC_OPCODE)
      && (dcr_opcode(instr_reg) != SKIP_OPCODE)) |-> !o_reg_we)
      else $error("foreign opcode wrote the register file");

   skip_write_a: assert property (
      (in_four && is_skip && dest_reg_sel) |->
      (o_reg_we && (o_reg_addr == instr_reg[ADDR_HI:ADDR_LO])))
      else $error("countdown result not written back");

   skip_acc_a: assert property (
      (in_four && is_skip && !dest_reg_sel) |->
      (!o_reg_we ##1 (o_acc == $past(result_reg))))
      else $error("countdown accumulator destination wrong");

   strobe_single_a: assert property (
      o_reg_we |-> in_four ##1 !o_reg_we)
      else $error("write strobe outside phase four");

   wdata_hold_a: assert property (
      (ph.phase != PH_THREE) |=> $stable(o_reg_wdata))
      else $error("write data moved outside process phase");

   acc_hold_a: assert property (
      !(in_four && (is_dec || is_skip) && !dest_reg_sel) |=> $stable(o_acc))
      else $error("accumulator changed without a destination");

endmodule

// [verif/dcr_mem_model.sv]
module dcr_mem_model (
   input  wire logic                          i_clk,
   input  wire logic [dcr_pkg::PC_W-1:0]      i_pc,
   input  wire logic [dcr_pkg::REG_ADDR_W-1:0] i_addr,
   input  wire logic [dcr_pkg::DATA_W-1:0]    i_wdata,
   input  wire logic                          i_we,
   output logic      [dcr_pkg::INSTR_W-1:0]   o_instr,
   output logic      [dcr_pkg::DATA_W-1:0]    o_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import dcr_pkg::*;
   logic [INSTR_W-1:0] prog [0:255];
   logic [DATA_W-1:0]  regs [0:127];
   // both reads combinational, as the core samples them at phase edges
   assign o_instr = prog[i_pc[7:0]];
   assign o_rdata = regs[i_addr];
   // plain always: the bench preloads this array by hierarchical writes
   always @(posedge i_clk) begin
      if (i_we) begin
         regs[i_addr] <= i_wdata;
      end
   end
endmodule

// [verif/decrement_file_instruction_test.sv]
module decrement_file_instruction_test;
   timeunit 1ns;
   timeprecision 1ns;
   import dcr_pkg::*;
   typedef struct packed {
      logic [PC_W-1:0]   pc;
      logic [DATA_W-1:0] acc;
      logic              z;
      logic              nop;
   } dcr_state_t;
   localparam int N = 50;
   logic clk, nrst, we, zero, nop, cstart;
   logic [INSTR_W-1:0] instr;
   logic [DATA_W-1:0]  rdata, wdata, acc;
   logic [PC_W-1:0]    pc;
   logic [REG_ADDR_W-1:0] addr;
   logic [14:0] wq [$];
   dcr_state_t  sq [$];
   int n_mismatch = 0;
   int cmp_count = 0;
   dcr_core #(.SKIP_OPCODE(SKIP_OPCODE_DEF)) dcr_core_inst (
      .i_clk(clk), .i_nrst(nrst), .i_instr(instr), .i_reg_rdata(rdata),
      .o_pc(pc), .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_we(we),
      .o_acc(acc), .o_zero(zero), .o_nop_cycle(nop), .o_cycle_start(cstart));
   dcr_mem_model dcr_mem_model_inst (
      .i_clk(clk), .i_pc(pc), .i_addr(addr), .i_wdata(wdata), .i_we(we),
      .o_instr(instr), .o_rdata(rdata));
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // sampled before the edge updates land, so phase-four pulses are seen
   always @(posedge clk) begin
      if (nrst === 1'b1 && we === 1'b1) begin
         if (wq.size() == 0) check("stray write", 0, 1);
         else check("write", wq.pop_front(), {addr, wdata});
      end
      if (nrst === 1'b1 && cstart === 1'b1 && sq.size() > 0) begin
         check("cycle state", sq.pop_front(), {pc, acc, zero, nop});
      end
   end
   initial begin
      #(40 * 4 * (N + 20));
      n_mismatch++;
      $display("[FAIL] watchdog expected done seen hang");
      tally_and_finish();
   end
   initial begin
      logic [15:0] r;
      logic [DATA_W-1:0] mir [0:127];
      logic [DATA_W-1:0] a, res;
      logic z, skip;
      logic [OPC_W-1:0] opc, tbl [0:3];
      logic [INSTR_W-1:0] w;
      nrst = 1'b0;
      r = 16'ha135;
      a = DATA_RESET;
      z = 1'b0;
      skip = 1'b0;
      tbl = '{DEC_OPCODE, SKIP_OPCODE_DEF, DEC_OPCODE, 6'h0a};
      for (int i = 0; i < 128; i++) begin
         r = lfsr(r);
         mir[i] = (i inside {5, 6}) ? 8'h01 : (i == 7) ? 8'h02 : r[7:0];
         dcr_mem_model_inst.regs[i] = mir[i];
      end
      // zero result, wrap to ff, taken skip, flushed word, untaken, other
      dcr_mem_model_inst.prog[0] = {DEC_OPCODE, 1'b1, 7'h05};
      dcr_mem_model_inst.prog[1] = {DEC_OPCODE, 1'b0, 7'h05};
      dcr_mem_model_inst.prog[2] = {SKIP_OPCODE_DEF, 1'b1, 7'h06};
      dcr_mem_model_inst.prog[3] = {DEC_OPCODE, 1'b1, 7'h07};
      dcr_mem_model_inst.prog[4] = {SKIP_OPCODE_DEF, 1'b1, 7'h07};
      dcr_mem_model_inst.prog[5] = {6'h0a, 1'b1, 7'h07};
      for (int i = 6; i < 256; i++) begin
         r = lfsr(r);
         w = {tbl[r[1:0]], r[2], r[15:9]};
         dcr_mem_model_inst.prog[i] = (i < N) ? w : INSTR_RESET;
      end
      for (int k = 0; k <= N; k++) begin
         sq.push_back({k[PC_W-1:0], a, z, skip});
         w = dcr_mem_model_inst.prog[k];
         opc = w[OPC_HI:OPC_LO];
         if (skip) begin
            skip = 1'b0;
         end else if (k < N &&
                      (opc == DEC_OPCODE || opc == SKIP_OPCODE_DEF)) begin
            res = mir[w[ADDR_HI:ADDR_LO]] - DEC_STEP;
            if (w[DEST_BIT]) begin
               wq.push_back({w[ADDR_HI:ADDR_LO], res});
               mir[w[ADDR_HI:ADDR_LO]] = res;
            end else begin
               a = res;
            end
            if (opc == DEC_OPCODE) z = (res == DATA_ZERO);
            else skip = (res == DATA_ZERO);
         end
      end
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (4 * (N + 2)) @(posedge clk);
      @(negedge clk);
      check("writes left", 0, wq.size());
      check("cycles left", 0, sq.size());
      $display("test decrement_sequence done");
      tally_and_finish();
   end
endmodule
